// [rtl/flash_host_defines.svh]
`ifndef FLASH_HOST_DEFINES_SVH
`define FLASH_HOST_DEFINES_SVH

// Bus widths of the flash part
`define ADDR_W 19
`define DATA_W 16

// Clock and pin timing
`define CLK_NS 50
`define T_WAKE_NS 300
`define T_ACC_NS 120
`define T_WP_NS 50
`define WAKE_CYC ((`T_WAKE_NS + `CLK_NS - 1) / `CLK_NS)
`define ACC_CYC ((`T_ACC_NS + `CLK_NS - 1) / `CLK_NS)
`define WP_CYC ((`T_WP_NS + `CLK_NS - 1) / `CLK_NS)

// Command codes written on the low data byte
`define CMD_ERASE_SETUP 8'h20
`define CMD_CONFIRM 8'hD0
`define CMD_READ_ARRAY 8'hFF
`define CMD_READ_STATUS 8'h70
`define CMD_CLEAR_STATUS 8'h50
`define CMD_SUSPEND 8'hB0

// Field positions of status_flags
`define BIT_ENGINE_READY 7
`define BIT_SUSPENDED 6
`define BIT_ERASE_FAIL 5
`define BIT_PROGRAM_FAIL 4
`define BIT_SUPPLY_LOW 3

`endif

// [rtl/flash_host_pkg.sv]
package flash_host_pkg;

    typedef enum logic [2:0] {
        OP_ERASE, OP_SUSPEND, OP_RESUME, OP_READ,
        OP_STATUS, OP_CLEAR, OP_POWER_DOWN, OP_WAKE
    } op_t;

    typedef enum {
        ST_RST_HOLD, ST_WAKE_WAIT, ST_FIRST_READ, ST_IDLE,
        ST_ERASE_SETUP, ST_ERASE_CONFIRM, ST_POLL, ST_SUSPEND_WR,
        ST_RESUME_WR, ST_CLEAR, ST_TO_ARRAY, ST_READ_CMD,
        ST_STATUS_CMD, ST_READ_DATA, ST_DONE, ST_PDOWN
    } state_t;

    typedef enum {PH_IDLE, PH_SETUP, PH_ACTIVE, PH_RECOVER} phase_t;

    typedef struct packed {
        op_t op;
        logic [18:0] addr;
    } req_t;

    typedef struct packed {
        logic [15:0] data;
        logic [7:0] status;
        logic supply_low;
        logic seq_error;
        logic erase_fail;
        logic refused;
    } rsp_t;

    typedef struct packed {
        logic ce_n;
        logic oe_n;
        logic we_n;
        logic powerdown_reset_n;
    } ctl_t;

endpackage

// [rtl/bus_cycle_timer.sv]
`timescale 1ns/1ps
`default_nettype none

module bus_cycle_timer (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic load_i,
    input wire logic [3:0] count_i,
    output logic done_o
);
    logic [3:0] cnt_ff;
    logic [3:0] nxt_cnt;

    assign nxt_cnt = load_i ? count_i : ((cnt_ff != 4'h0) ? cnt_ff - 4'h1 : cnt_ff);
    assign done_o = (cnt_ff == 4'h0) && !load_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_ff <= 4'h0;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end
endmodule // bus_cycle_timer

`default_nettype wire

// [rtl/flash_erase_host.sv]
`timescale 1ns/1ps
`default_nettype none
`include "flash_host_defines.svh"

// Contract
// - Host issues erase-resume after other-block reads; engine finishes the erase.
// - After a resumed erase ends, host reads status, clears it, then continues.
// - Erase starts with 20H then D0H, both at an address in the block.
// - Host toggles OE or CE per status read; bit 7 high means ready.
// - After the last erase the host writes FFH to return to array read.
// - Host clears status after an error before any retry or recovery.
// - After power-up host selects the chip or presents an address before reading.
// - Command write only with write strobe and chip select both low.
module flash_erase_host (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic REQ_VALID_I,
    input wire flash_host_pkg::req_t REQ_I,
    output logic REQ_READY_O,
    output logic RSP_VALID_O,
    output var flash_host_pkg::rsp_t RSP_O,
    output var flash_host_pkg::ctl_t FL_CTL_O,
    output logic [`ADDR_W-1:0] FL_ADDR_O,
    input wire logic [`DATA_W-1:0] FL_DQ_I,
    output logic [`DATA_W-1:0] FL_DQ_O,
    output logic FL_DQ_OE_N_O
);
    flash_host_pkg::state_t state_ff, nxt_state;
    flash_host_pkg::phase_t phase_ff, nxt_phase;
    flash_host_pkg::op_t op_ff;
    flash_host_pkg::rsp_t rsp_ff, nxt_rsp;
    logic [`ADDR_W-1:0] addr_ff;
    logic [`DATA_W-1:0] dq_ff, rdata_ff;
    logic [7:0] status_ff;
    logic suspended_ff, susp_pend_ff, rsp_valid_ff;
    logic wr_step, rd_step, in_cycle, cyc_end, read_end, tmr_done, tmr_load;
    logic take, go, refuse, op_bad, erase_running, suspend_slot;
    logic [7:0] cmd_code;
    logic [3:0] tmr_count;

    ////////////////////////////////////////////////////////////////////////////
    // Step decode

    assign wr_step = (state_ff == flash_host_pkg::ST_ERASE_SETUP)
        || (state_ff == flash_host_pkg::ST_ERASE_CONFIRM)
        || (state_ff == flash_host_pkg::ST_SUSPEND_WR)
        || (state_ff == flash_host_pkg::ST_RESUME_WR)
        || (state_ff == flash_host_pkg::ST_CLEAR)
        || (state_ff == flash_host_pkg::ST_TO_ARRAY)
        || (state_ff == flash_host_pkg::ST_READ_CMD)
        || (state_ff == flash_host_pkg::ST_STATUS_CMD);
    assign rd_step = (state_ff == flash_host_pkg::ST_POLL)
        || (state_ff == flash_host_pkg::ST_READ_DATA)
        || (state_ff == flash_host_pkg::ST_FIRST_READ);
    // Confirm and resume share one code; both go to addr_ff, the block address for confirm but the resume request's own address for resume
    assign cmd_code = (state_ff == flash_host_pkg::ST_ERASE_SETUP) ? `CMD_ERASE_SETUP :
        (state_ff == flash_host_pkg::ST_ERASE_CONFIRM) ? `CMD_CONFIRM :
        (state_ff == flash_host_pkg::ST_RESUME_WR) ? `CMD_CONFIRM :
        (state_ff == flash_host_pkg::ST_SUSPEND_WR) ? `CMD_SUSPEND :
        (state_ff == flash_host_pkg::ST_CLEAR) ? `CMD_CLEAR_STATUS :
        (state_ff == flash_host_pkg::ST_STATUS_CMD) ? `CMD_READ_STATUS : `CMD_READ_ARRAY;

    assign in_cycle = (phase_ff == flash_host_pkg::PH_SETUP)
        || (phase_ff == flash_host_pkg::PH_ACTIVE);
    assign cyc_end = (phase_ff == flash_host_pkg::PH_RECOVER);
    assign read_end = (phase_ff == flash_host_pkg::PH_ACTIVE) && tmr_done && rd_step;

    ////////////////////////////////////////////////////////////////////////////
    // Request port

    assign erase_running = (op_ff == flash_host_pkg::OP_ERASE)
        || (op_ff == flash_host_pkg::OP_RESUME);
    // A suspend is only taken while an erase is being polled
    assign suspend_slot = (state_ff == flash_host_pkg::ST_POLL) && erase_running
        && !susp_pend_ff && (REQ_I.op == flash_host_pkg::OP_SUSPEND);
    assign REQ_READY_O = (state_ff == flash_host_pkg::ST_IDLE)
        || (state_ff == flash_host_pkg::ST_PDOWN) || suspend_slot;
    assign take = REQ_VALID_I && REQ_READY_O;
    assign op_bad = suspended_ff ?
        !((REQ_I.op == flash_host_pkg::OP_READ) || (REQ_I.op == flash_host_pkg::OP_STATUS)
        || (REQ_I.op == flash_host_pkg::OP_RESUME)
        || (REQ_I.op == flash_host_pkg::OP_POWER_DOWN)) :
        ((REQ_I.op == flash_host_pkg::OP_RESUME) || (REQ_I.op == flash_host_pkg::OP_WAKE)
        || (REQ_I.op == flash_host_pkg::OP_SUSPEND));
    assign refuse = take && (((state_ff == flash_host_pkg::ST_IDLE) && op_bad)
        || ((state_ff == flash_host_pkg::ST_PDOWN) && (REQ_I.op != flash_host_pkg::OP_WAKE)));
    assign go = take && !refuse;

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            flash_host_pkg::ST_RST_HOLD: nxt_state = flash_host_pkg::ST_WAKE_WAIT;
            flash_host_pkg::ST_WAKE_WAIT: if (tmr_done) nxt_state = flash_host_pkg::ST_FIRST_READ;
            flash_host_pkg::ST_FIRST_READ: if (cyc_end) begin
                nxt_state = (op_ff == flash_host_pkg::OP_WAKE) ?
                    flash_host_pkg::ST_DONE : flash_host_pkg::ST_IDLE;
            end
            flash_host_pkg::ST_IDLE: if (go) begin
                case (REQ_I.op)
                    flash_host_pkg::OP_ERASE: nxt_state = flash_host_pkg::ST_ERASE_SETUP;
                    flash_host_pkg::OP_RESUME: nxt_state = flash_host_pkg::ST_RESUME_WR;
                    flash_host_pkg::OP_READ: nxt_state = flash_host_pkg::ST_READ_CMD;
                    flash_host_pkg::OP_STATUS: nxt_state = flash_host_pkg::ST_STATUS_CMD;
                    flash_host_pkg::OP_CLEAR: nxt_state = flash_host_pkg::ST_CLEAR;
                    flash_host_pkg::OP_POWER_DOWN: nxt_state = flash_host_pkg::ST_PDOWN;
                    default: nxt_state = flash_host_pkg::ST_IDLE;
                endcase
            end
            flash_host_pkg::ST_ERASE_SETUP: if (cyc_end) nxt_state = flash_host_pkg::ST_ERASE_CONFIRM;
            flash_host_pkg::ST_ERASE_CONFIRM: if (cyc_end) nxt_state = flash_host_pkg::ST_POLL;
            flash_host_pkg::ST_POLL: if (cyc_end) begin
                if (susp_pend_ff) begin
                    nxt_state = flash_host_pkg::ST_SUSPEND_WR;
                end else if (rdata_ff[`BIT_ENGINE_READY]) begin
                    nxt_state = (op_ff == flash_host_pkg::OP_SUSPEND) ?
                        flash_host_pkg::ST_DONE : flash_host_pkg::ST_CLEAR;
                end
            end
            flash_host_pkg::ST_SUSPEND_WR: if (cyc_end) nxt_state = flash_host_pkg::ST_POLL;
            flash_host_pkg::ST_RESUME_WR: if (cyc_end) nxt_state = flash_host_pkg::ST_POLL;
            flash_host_pkg::ST_CLEAR: if (cyc_end) begin
                nxt_state = (op_ff == flash_host_pkg::OP_CLEAR) ?
                    flash_host_pkg::ST_DONE : flash_host_pkg::ST_TO_ARRAY;
            end
            flash_host_pkg::ST_TO_ARRAY: if (cyc_end) nxt_state = flash_host_pkg::ST_DONE;
            flash_host_pkg::ST_READ_CMD: if (cyc_end) nxt_state = flash_host_pkg::ST_READ_DATA;
            flash_host_pkg::ST_STATUS_CMD: if (cyc_end) nxt_state = flash_host_pkg::ST_READ_DATA;
            flash_host_pkg::ST_READ_DATA: if (cyc_end) nxt_state = flash_host_pkg::ST_DONE;
            flash_host_pkg::ST_DONE: nxt_state = flash_host_pkg::ST_IDLE;
            flash_host_pkg::ST_PDOWN: if (go) nxt_state = flash_host_pkg::ST_WAKE_WAIT;
            default: nxt_state = flash_host_pkg::ST_IDLE;
        endcase
    end

    // Every bus cycle has idle and recovery cycles with CE and OE high around it
    always_comb begin
        nxt_phase = phase_ff;
        case (phase_ff)
            flash_host_pkg::PH_IDLE: if (wr_step || rd_step) nxt_phase = flash_host_pkg::PH_SETUP;
            flash_host_pkg::PH_SETUP: nxt_phase = flash_host_pkg::PH_ACTIVE;
            flash_host_pkg::PH_ACTIVE: if (tmr_done) nxt_phase = flash_host_pkg::PH_RECOVER;
            flash_host_pkg::PH_RECOVER: nxt_phase = flash_host_pkg::PH_IDLE;
            default: nxt_phase = flash_host_pkg::PH_IDLE;
        endcase
    end

    assign tmr_load = (phase_ff == flash_host_pkg::PH_SETUP)
        || (state_ff == flash_host_pkg::ST_RST_HOLD)
        || ((state_ff == flash_host_pkg::ST_PDOWN) && go);
    // Wake wait covers the device's recovery from deep power-down
    assign tmr_count = (phase_ff == flash_host_pkg::PH_SETUP) ?
        (wr_step ? 4'(`WP_CYC - 1) : 4'(`ACC_CYC - 1)) : 4'(`WAKE_CYC - 1);

    bus_cycle_timer u_timer (
        .clk_i(CLK_I),
        .rst_i(RST_I),
        .load_i(tmr_load),
        .count_i(tmr_count),
        .done_o(tmr_done)
    );

    // Errors are decoded from the last status byte read
    assign nxt_rsp.data = rdata_ff;
    assign nxt_rsp.status = status_ff;
    assign nxt_rsp.supply_low = status_ff[`BIT_SUPPLY_LOW];
    assign nxt_rsp.seq_error = status_ff[`BIT_ERASE_FAIL] && status_ff[`BIT_PROGRAM_FAIL];
    assign nxt_rsp.erase_fail = status_ff[`BIT_ERASE_FAIL] && !status_ff[`BIT_PROGRAM_FAIL];
    assign nxt_rsp.refused = refuse;

    always_ff @(posedge CLK_I) begin
        if (RST_I) begin
            state_ff <= flash_host_pkg::ST_RST_HOLD;
            phase_ff <= flash_host_pkg::PH_IDLE;
            op_ff <= flash_host_pkg::OP_READ;
            addr_ff <= 19'h0_0000;
            dq_ff <= 16'h0000;
            rdata_ff <= 16'h0000;
            status_ff <= 8'h00;
            suspended_ff <= 1'b0;
            susp_pend_ff <= 1'b0;
            rsp_valid_ff <= 1'b0;
            rsp_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            phase_ff <= nxt_phase;
            if (go || suspend_slot && take) op_ff <= REQ_I.op;
            if (go && (state_ff == flash_host_pkg::ST_IDLE)) addr_ff <= REQ_I.addr;
            if (nxt_phase == flash_host_pkg::PH_SETUP) dq_ff <= {8'h00, cmd_code};
            if (read_end) rdata_ff <= FL_DQ_I;
            if (read_end && ((state_ff == flash_host_pkg::ST_POLL)
                || (op_ff == flash_host_pkg::OP_STATUS))) status_ff <= FL_DQ_I[7:0];
            if (take && suspend_slot) begin
                susp_pend_ff <= 1'b1;
            end else if ((state_ff == flash_host_pkg::ST_SUSPEND_WR)
                || (state_ff == flash_host_pkg::ST_DONE)) begin
                // A suspend that lost the race with erase completion must not linger
                susp_pend_ff <= 1'b0;
            end
            // Power-down aborts the erase, so the suspended erase is gone too
            if (go && ((REQ_I.op == flash_host_pkg::OP_RESUME)
                || (REQ_I.op == flash_host_pkg::OP_POWER_DOWN))) begin
                suspended_ff <= 1'b0;
            end else if ((state_ff == flash_host_pkg::ST_DONE)
                && (op_ff == flash_host_pkg::OP_SUSPEND)) begin
                suspended_ff <= status_ff[`BIT_SUSPENDED];
            end
            rsp_valid_ff <= (state_ff == flash_host_pkg::ST_DONE) || refuse
                || (go && (REQ_I.op == flash_host_pkg::OP_POWER_DOWN));
            rsp_ff <= nxt_rsp;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pins

    assign FL_CTL_O.ce_n = !in_cycle;
    assign FL_CTL_O.oe_n = !((phase_ff == flash_host_pkg::PH_ACTIVE) && rd_step);
    assign FL_CTL_O.we_n = !((phase_ff == flash_host_pkg::PH_ACTIVE) && wr_step);
    assign FL_CTL_O.powerdown_reset_n = !((state_ff == flash_host_pkg::ST_RST_HOLD)
        || (state_ff == flash_host_pkg::ST_PDOWN));
    assign FL_ADDR_O = addr_ff;
    assign FL_DQ_O = dq_ff;
    assign FL_DQ_OE_N_O = !(wr_step && in_cycle);
    assign RSP_VALID_O = rsp_valid_ff;
    assign RSP_O = rsp_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    AST_WE_NEEDS_CE: assert property (@(posedge CLK_I) disable iff (RST_I)
        !FL_CTL_O.we_n |-> !FL_CTL_O.ce_n && FL_CTL_O.oe_n && !FL_DQ_OE_N_O)
        else $error("Write strobe low without chip select or data drive");
    AST_CONFIRM_FOLLOWS_SETUP: assert property (@(posedge CLK_I) disable iff (RST_I)
        $rose(state_ff == flash_host_pkg::ST_ERASE_CONFIRM)
        |-> $past(state_ff) == flash_host_pkg::ST_ERASE_SETUP && $stable(addr_ff)
        ##2 !FL_CTL_O.we_n && FL_DQ_O[7:0] == `CMD_CONFIRM)
        else $error("Erase confirm not written right after setup");
    AST_STATUS_TOGGLE: assert property (@(posedge CLK_I) disable iff (RST_I)
        $rose(FL_CTL_O.oe_n) |-> FL_CTL_O.ce_n ##1 (FL_CTL_O.ce_n && FL_CTL_O.oe_n))
        else $error("Read strobes not toggled between status reads");
    AST_RESUME_CODE: assert property (@(posedge CLK_I) disable iff (RST_I)
        (state_ff == flash_host_pkg::ST_RESUME_WR && cyc_end)
        |-> $past(FL_DQ_O[7:0], 2) == `CMD_CONFIRM ##1 state_ff == flash_host_pkg::ST_POLL)
        else $error("Resume not followed by polling of the erase");
    AST_CLEAR_AFTER_POLL: assert property (@(posedge CLK_I) disable iff (RST_I)
        ($rose(state_ff == flash_host_pkg::ST_CLEAR) && op_ff != flash_host_pkg::OP_CLEAR)
        |-> $past(state_ff) == flash_host_pkg::ST_POLL && rdata_ff[`BIT_ENGINE_READY])
        else $error("Status clear without a ready status read");
    AST_CLEAR_CODE: assert property (@(posedge CLK_I) disable iff (RST_I)
        (state_ff == flash_host_pkg::ST_CLEAR && !FL_CTL_O.we_n)
        |-> FL_DQ_O[7:0] == `CMD_CLEAR_STATUS)
        else $error("Wrong code during status clear");
    AST_ARRAY_AFTER_CLEAR: assert property (@(posedge CLK_I) disable iff (RST_I)
        (state_ff == flash_host_pkg::ST_CLEAR && cyc_end && op_ff != flash_host_pkg::OP_CLEAR)
        |=> ##[1:4] (!FL_CTL_O.we_n && FL_DQ_O[7:0] == `CMD_READ_ARRAY))
        else $error("No array read command after erase completion");
    AST_FIRST_ACCESS: assert property (@(posedge CLK_I) disable iff (RST_I)
        (state_ff == flash_host_pkg::ST_WAKE_WAIT && tmr_done)
        |=> state_ff == flash_host_pkg::ST_FIRST_READ ##2 (!FL_CTL_O.ce_n && !FL_CTL_O.oe_n))
        else $error("Chip not selected after wake");
endmodule // flash_erase_host

`default_nettype wire

// [tb/flash_device_model.sv]
`timescale 1ns/1ps
`default_nettype none

module flash_device_model (
    input wire flash_host_pkg::ctl_t ctl_i,
    input wire logic [18:0] addr_i,
    input wire logic [15:0] dq_i,
    input wire logic supply_low_i,
    input wire logic fail_i,
    input wire logic [7:0] busy_reads_i,
    output logic [15:0] dq_o
);
    logic [7:0] sr_ff = 8'h80;
    logic [7:0] busy_ff = 8'h00;
    logic stat_ff = 1'b0;
    logic setup_ff = 1'b0;
    logic [15:0] rd_ff = 16'h0000;
    wire logic [7:0] cmd = dq_i[7:0];
    wire logic sel = !ctl_i.ce_n && !ctl_i.oe_n && ctl_i.powerdown_reset_n;

    ////////////////////////////////////////////////////////////
    always @(negedge ctl_i.powerdown_reset_n) begin
        sr_ff = 8'h00;
        busy_ff = 8'h00;
        stat_ff = 1'b0;
        setup_ff = 1'b0;
    end
    always @(posedge ctl_i.powerdown_reset_n) begin
        sr_ff[7] = 1'b1;
    end

    // Taken at the strobe's fall: data is set a cycle earlier, and the rising edge races CE
    always @(negedge ctl_i.we_n) begin
        if (!ctl_i.ce_n && ctl_i.powerdown_reset_n) begin
            stat_ff = 1'b1;
            if (setup_ff) begin
                setup_ff = 1'b0;
                if (cmd != 8'hD0) begin
                    sr_ff[5:4] = 2'b11;
                end else if (supply_low_i || sr_ff[3]) begin
                    sr_ff[5] = 1'b1;
                    sr_ff[3] = 1'b1;
                end else begin
                    busy_ff = busy_reads_i;
                    sr_ff[7] = 1'b0;
                end
            end else if (cmd == 8'h20) begin
                setup_ff = !sr_ff[6];
            end else if (cmd == 8'hFF) begin
                stat_ff = 1'b0;
            end else if (cmd == 8'h50 && !sr_ff[6]) begin
                sr_ff[5:3] = 3'b000;
            end else if (cmd == 8'hB0 && busy_ff != 8'h00) begin
                sr_ff[7:6] = 2'b11;
            end else if (cmd == 8'hD0 && sr_ff[6]) begin
                sr_ff[7:6] = 2'b00;
            end
        end
    end

    // Frozen at the later falling edge so a poll never sees a torn value
    always @(negedge ctl_i.oe_n or negedge ctl_i.ce_n) begin
        // Pins tested directly: the sel net may not have settled when this wakes
        if (!ctl_i.ce_n && !ctl_i.oe_n && ctl_i.powerdown_reset_n) begin
            rd_ff = stat_ff ? {8'h00, sr_ff} : (addr_i[15:0] ^ 16'h5A5A);
            if (stat_ff && busy_ff != 8'h00 && !sr_ff[6]) begin
                busy_ff = busy_ff - 8'h01;
                sr_ff[7] = (busy_ff == 8'h00);
                sr_ff[5] = sr_ff[5] | (fail_i && busy_ff == 8'h00);
            end
        end
    end
    // Released bus shows the inverse, never a stale value
    assign dq_o = sel ? rd_ff : ~rd_ff;
endmodule // flash_device_model

`default_nettype wire

// [tb/flash_erase_power_control_tb.sv]
`timescale 1ns/1ps
`default_nettype none

module flash_erase_power_control_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic req_valid = 1'b0;
    flash_host_pkg::req_t req = '0;
    logic req_ready;
    logic rsp_valid;
    flash_host_pkg::rsp_t rsp;
    flash_host_pkg::rsp_t got;
    flash_host_pkg::ctl_t fl_ctl;
    logic [18:0] fl_addr;
    logic [15:0] host_dq;
    logic [15:0] dev_dq;
    logic dq_oe_n;
    logic supply_low = 1'b0;
    logic fail = 1'b0;
    logic [7:0] busy_reads = 8'h03;
    int num_errors = 0;
    int n_compared = 0;
    logic [7:0] cmd_log[$];
    logic [18:0] addr_log[$];
    wire logic [15:0] dq_bus = dq_oe_n ? dev_dq : host_dq;

    always #25 clk = ~clk;

    flash_erase_host i_dut (
        .CLK_I(clk), .RST_I(rst), .REQ_VALID_I(req_valid), .REQ_I(req),
        .REQ_READY_O(req_ready), .RSP_VALID_O(rsp_valid), .RSP_O(rsp),
        .FL_CTL_O(fl_ctl), .FL_ADDR_O(fl_addr), .FL_DQ_I(dq_bus),
        .FL_DQ_O(host_dq), .FL_DQ_OE_N_O(dq_oe_n)
    );
    flash_device_model i_flash (
        .ctl_i(fl_ctl), .addr_i(fl_addr), .dq_i(dq_bus), .supply_low_i(supply_low),
        .fail_i(fail), .busy_reads_i(busy_reads), .dq_o(dev_dq)
    );

    ////////////////////////////////////////////////////////////
    always @(negedge fl_ctl.we_n) begin
        cmd_log.push_back(dq_bus[7:0]);
        addr_log.push_back(fl_addr);
        chk("write sel", {14'h0000, fl_ctl.ce_n, dq_oe_n}, 16'h0000);
    end

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic end_sim();
        if (num_errors == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic guard(input int n);
        if (n > 4000) begin
            num_errors++;
            end_sim();
        end
    endtask

    task automatic send(input flash_host_pkg::op_t op, input logic [18:0] a);
        int n;
        n = 0;
        @(posedge clk);
        #5;
        req = '{op: op, addr: a};
        req_valid = 1'b1;
        @(negedge clk);
        while (req_ready !== 1'b1) begin
            n++;
            guard(n);
            @(negedge clk);
        end
        @(posedge clk);
        #5 req_valid = 1'b0;
    endtask

    task automatic call(input flash_host_pkg::op_t op, input logic [18:0] a);
        int n;
        n = 0;
        send(op, a);
        // Sampled mid-cycle, clear of the edge that launches the pulse
        @(negedge clk);
        while (rsp_valid !== 1'b1) begin
            n++;
            guard(n);
            @(negedge clk);
        end
        got = rsp;
        #5;
    endtask

    ////////////////////////////////////////////////////////////
    task automatic t_basic();
        call(flash_host_pkg::OP_READ, 19'h0_1234);
        chk("read data", got.data, 16'h486E);
        chk("idle pins", {12'h000, fl_ctl}, 16'h000F);
        call(flash_host_pkg::OP_STATUS, 19'h0_1234);
        chk("status", {8'h00, got.status}, 16'h0080);
        cmd_log = {};
        call(flash_host_pkg::OP_CLEAR, 19'h0_0000);
        chk("clear cmd", {8'h00, cmd_log[0]}, 16'h0050);
    endtask

    task automatic t_erase(input logic [18:0] a, input logic f, input logic s, input logic [7:0] st);
        fail = f;
        supply_low = s;
        cmd_log = {};
        addr_log = {};
        call(flash_host_pkg::OP_ERASE, a);
        chk("erase st", {8'h00, got.status}, {8'h00, st});
        chk("flags", {13'h0000, got.supply_low, got.seq_error, got.erase_fail},
            {13'h0000, st[3], 1'b0, st[5]});
        chk("setup", {cmd_log[0], cmd_log[1]}, 16'h20D0);
        chk("block", {15'h0000, addr_log[0] === a && addr_log[1] === a}, 16'h0001);
        chk("tail", {cmd_log[2], cmd_log[3]}, 16'h50FF);
    endtask

    // Erase held long enough that the suspend lands in mid-poll
    task automatic t_suspend();
        busy_reads = 8'h28;
        send(flash_host_pkg::OP_ERASE, 19'h2_0010);
        call(flash_host_pkg::OP_SUSPEND, 19'h0_0000);
        chk("susp st", {8'h00, got.status}, 16'h00C0);
        chk("deselect", {15'h0000, fl_ctl.ce_n}, 16'h0001);
        call(flash_host_pkg::OP_READ, 19'h0_0042);
        chk("susp read", got.data, 16'h5A18);
        cmd_log = {};
        call(flash_host_pkg::OP_ERASE, 19'h2_0010);
        chk("susp erase", {15'h0000, got.refused}, 16'h0001);
        chk("no write", {15'h0000, cmd_log.size() == 0}, 16'h0001);
        call(flash_host_pkg::OP_RESUME, 19'h0_0000);
        chk("resume st", {8'h00, got.status}, 16'h0080);
        call(flash_host_pkg::OP_RESUME, 19'h0_0000);
        chk("stray resume", {15'h0000, got.refused}, 16'h0001);
    endtask

    task automatic t_pdown();
        send(flash_host_pkg::OP_ERASE, 19'h3_0000);
        call(flash_host_pkg::OP_SUSPEND, 19'h0_0000);
        call(flash_host_pkg::OP_POWER_DOWN, 19'h0_0000);
        chk("rp low", {15'h0000, fl_ctl.powerdown_reset_n}, 16'h0000);
        cmd_log = {};
        call(flash_host_pkg::OP_READ, 19'h0_0042);
        chk("pd refuse", {15'h0000, got.refused}, 16'h0001);
        chk("pd quiet", {15'h0000, cmd_log.size() == 0}, 16'h0001);
        call(flash_host_pkg::OP_WAKE, 19'h0_0000);
        chk("wake", {15'h0000, got.refused}, 16'h0000);
        chk("wake data", got.data, 16'h5A5A);
        call(flash_host_pkg::OP_STATUS, 19'h0_0000);
        chk("pd status", {8'h00, got.status}, 16'h0080);
    endtask

    initial begin
        repeat (10) @(posedge clk);
        chk("reset rp", {15'h0000, fl_ctl.powerdown_reset_n}, 16'h0000);
        #5 rst = 1'b0;
        t_basic();
        t_erase(19'h1_0000, 1'b0, 1'b0, 8'h80);
        t_erase(19'h1_2000, 1'b1, 1'b0, 8'hA0);
        t_erase(19'h1_4000, 1'b0, 1'b1, 8'hA8);
        t_erase(19'h1_6000, 1'b0, 1'b0, 8'h80);
        t_suspend();
        t_pdown();
        end_sim();
    end
endmodule // flash_erase_power_control_tb

`default_nettype wire
